// ==== logic/pbm_pkg.sv ====
package pbm_pkg;

  // Data path geometry
  localparam int unsigned DATA_W = 128;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned TAG_W = 8;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned NARROW_W = 64;

  // Configuration space word holding the tolerance fields
  localparam int unsigned CFG_ADDR_W = 12;
  localparam logic [11:0] DEV_CAP_OFF = 12'h084;
  localparam int unsigned STANDBY_TOL_LSB = 6;
  localparam int unsigned SLEEP_TOL_LSB = 9;
  localparam logic [2:0] STANDBY_TOL_64NS = 3'h0;
  localparam logic [2:0] SLEEP_TOL_1US = 3'h0;

  // Bridge register slave map
  localparam int unsigned BRS_ADDR_W = 8;
  localparam logic [7:0] BRS_IRQ_EN_OFF = 8'h00;
  localparam logic [7:0] BRS_STATUS_OFF = 8'h04;
  localparam logic [7:0] BRS_CAP_OFF = 8'h08;
  localparam int unsigned IRQ_EN_BIT = 0;

  // Outstanding read tag queue
  localparam int unsigned TAGQ_DEPTH = 8;
  localparam int unsigned TAGQ_PTR_W = 3;
  localparam int unsigned TAGQ_CNT_W = 4;
  localparam logic [3:0] TAGQ_FULL = 4'h8;

  // MSI vector width
  localparam int unsigned MSI_NUM_W = 5;

  typedef enum logic [1:0] {
    PBM_MODE_REQ_CPL,
    PBM_MODE_CPL_ONLY,
    PBM_MODE_ONE_WORD
  } pbm_mode_t;

  typedef enum logic [1:0] {
    PBM_OW_IDLE,
    PBM_OW_ISSUE,
    PBM_OW_WAIT,
    PBM_OW_CPL
  } pbm_ow_state_t;

  typedef struct packed {
    logic write;
    logic [TAG_W-1:0] tag;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pbm_rx_req_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pbm_cmd_t;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [DATA_W-1:0] data;
  } pbm_cpl_t;

  typedef struct packed {
    logic req;
    logic [MSI_NUM_W-1:0] num;
  } pbm_msi_t;

endpackage : pbm_pkg

// ==== logic/pbm_bridge_mode_config.sv ====
`timescale 1ns/10ps

// Behaviour
// - Standby exit tolerance shows read-only in capability word at 0x084.
// - Standby exit tolerance defaults to the 64 ns encoding.
// - Sleep exit tolerance shows read-only, defaulting to the 1 us encoding.
// - Device never enters either low power link state on its own.
// - Root port build drops both tolerance fields.
// - Application data path is 64 or 128 bits, chosen at build.
// - Full mode both sends link requests and accepts incoming requests.
// - Completion-only mode accepts requests, sends completions, never originates requests.
// - One word target mode is non-pipelined, one request outstanding.
// - One word target mode carries 32 bits on the receive bar master.
// - Bridge register slave port gives fabric read/write register access.
// - Register port always present in full mode, optional in completion-only.
// - Register port absent in one word target mode.
// - Multiple MSI option exposes MSI interface at top level.
// - Interrupt enable powers up set when auto-enable chosen, else clear.
// - Auto-enable changes only reset value; software writes work normally.
module pbm_bridge_mode_config
  import pbm_pkg::*;
#(
  parameter pbm_mode_t PERIPH_MODE = PBM_MODE_REQ_CPL,
  parameter bit WIDE_PATH = 1'b1,
  parameter bit ROOT_PORT = 1'b0,
  parameter logic [2:0] STANDBY_TOL = STANDBY_TOL_64NS,
  parameter logic [2:0] SLEEP_TOL = SLEEP_TOL_1US,
  parameter bit BRS_OPTION = 1'b1,
  parameter bit MULTI_MSI = 1'b0,
  parameter bit AUTO_IRQ_EN = 1'b0
) (
  input wire logic clk_in,
  input wire logic srst_in,
  // Configuration space read from the link side
  input wire logic cfg_rd_in,
  input wire logic [CFG_ADDR_W-1:0] cfg_addr_in,
  output logic [WORD_W-1:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // Incoming requests from the transaction layer
  input wire pbm_rx_req_t rxreq_in,
  input wire logic rxreq_valid_in,
  output logic rxreq_ready_out,
  // Receive bar master toward the fabric
  output pbm_cmd_t rbm_cmd_out,
  output logic rbm_valid_out,
  input wire logic rbm_ready_in,
  input wire logic [DATA_W-1:0] rbm_rdata_in,
  input wire logic rbm_rvalid_in,
  // Completions toward the link
  output pbm_cpl_t cpl_out,
  output logic cpl_valid_out,
  input wire logic cpl_ready_in,
  // Transmit-side slave from the fabric
  input wire pbm_cmd_t txs_cmd_in,
  input wire logic txs_valid_in,
  output logic txs_ready_out,
  // Requests toward the link
  output pbm_cmd_t txreq_out,
  output logic txreq_valid_out,
  input wire logic txreq_ready_in,
  // Bridge register slave port
  input wire logic brs_sel_in,
  input wire logic brs_wr_in,
  input wire logic [BRS_ADDR_W-1:0] brs_addr_in,
  input wire logic [WORD_W-1:0] brs_wdata_in,
  output logic [WORD_W-1:0] brs_rdata_out,
  output logic brs_rvalid_out,
  // Interrupts
  input wire logic app_irq_in,
  input wire pbm_msi_t app_msi_in,
  output logic irq_out,
  output pbm_msi_t msi_out,
  // Link power state requests
  output logic standby_entry_out,
  output logic sleep_entry_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Build-time decode

  // Lanes the fabric side actually carries for the chosen mode and width
  function automatic logic [DATA_W-1:0] lane_mask(input pbm_mode_t mode, input bit wide);
    logic [DATA_W-1:0] m;
    m = '1;
    if (mode == PBM_MODE_ONE_WORD) begin
      m = {{(DATA_W-WORD_W){1'b0}}, {WORD_W{1'b1}}};
    end else if (!wide) begin
      m = {{(DATA_W-NARROW_W){1'b0}}, {NARROW_W{1'b1}}};
    end
    return m;
  endfunction : lane_mask

  localparam logic [DATA_W-1:0] LANES = lane_mask(PERIPH_MODE, WIDE_PATH);
  localparam bit ONE_WORD = (PERIPH_MODE == PBM_MODE_ONE_WORD);
  localparam bit CAN_REQUEST = (PERIPH_MODE == PBM_MODE_REQ_CPL);
  // Register port: forced in full mode, optional in completion-only, never in one word
  localparam bit BRS_PRESENT = (PERIPH_MODE == PBM_MODE_REQ_CPL) ||
    ((PERIPH_MODE == PBM_MODE_CPL_ONLY) && BRS_OPTION);

  // Tolerance fields vanish for a root port build
  localparam logic [2:0] STANDBY_FIELD = ROOT_PORT ? 3'h0 : STANDBY_TOL;
  localparam logic [2:0] SLEEP_FIELD = ROOT_PORT ? 3'h0 : SLEEP_TOL;

  // Read-only capability word; only the two tolerance fields are owned here
  localparam logic [WORD_W-1:0] DEV_CAP_WORD =
    (WORD_W'(STANDBY_FIELD) << STANDBY_TOL_LSB) |
    (WORD_W'(SLEEP_FIELD) << SLEEP_TOL_LSB);

  ////////////////////////////////////////////////////////////////////////////
  // Signals

  pbm_ow_state_t ow_state_ff;
  pbm_ow_state_t nxt_ow_state;
  logic rbm_valid_ff;
  pbm_cmd_t rbm_cmd_ff;
  pbm_cpl_t cpl_ff;
  logic cpl_valid_ff;
  pbm_cmd_t txreq_ff;
  logic txreq_valid_ff;
  logic [TAG_W-1:0] tagq_mem [TAGQ_DEPTH];
  logic [TAG_W-1:0] cur_tag_ff;
  logic [TAGQ_PTR_W-1:0] tagq_wptr_ff;
  logic [TAGQ_PTR_W-1:0] tagq_rptr_ff;
  logic [TAGQ_CNT_W-1:0] tagq_cnt_ff;
  logic irq_en_ff;
  logic irq_ff;
  pbm_msi_t msi_ff;
  logic [WORD_W-1:0] cfg_rdata_ff;
  logic cfg_rvalid_ff;
  logic [WORD_W-1:0] brs_rdata_ff;
  logic brs_rvalid_ff;
  logic rx_take;
  logic rbm_take;
  logic rd_issue;
  logic cpl_stall;
  logic pipe_ready;
  logic tx_take;

  ////////////////////////////////////////////////////////////////////////////
  // Receive request acceptance

  assign rbm_take = rbm_valid_ff && rbm_ready_in;
  assign rd_issue = rbm_take && !rbm_cmd_ff.write;
  // Returned read data has no back-pressure, so stop accepting requests while a completion waits
  assign cpl_stall = cpl_valid_ff && !cpl_ready_in;
  assign pipe_ready = (!rbm_valid_ff || rbm_ready_in) && !cpl_stall &&
    ((tagq_cnt_ff + TAGQ_CNT_W'(rbm_valid_ff)) < TAGQ_FULL); // Staged read counts, no overflow

  // One word target only takes a request from the idle state
  always_comb begin
    if (ONE_WORD) begin
      rxreq_ready_out = (ow_state_ff == PBM_OW_IDLE);
    end else begin
      rxreq_ready_out = pipe_ready;
    end
  end

  assign rx_take = rxreq_valid_in && rxreq_ready_out;

  // Non-pipelined sequencing for one word target mode
  always_comb begin
    nxt_ow_state = ow_state_ff;
    unique case (ow_state_ff)
      PBM_OW_IDLE: begin
        if (rx_take) begin
          nxt_ow_state = PBM_OW_ISSUE;
        end
      end
      PBM_OW_ISSUE: begin
        if (rbm_take) begin
          nxt_ow_state = rbm_cmd_ff.write ? PBM_OW_IDLE : PBM_OW_WAIT;
        end
      end
      PBM_OW_WAIT: begin
        if (rbm_rvalid_in) begin
          nxt_ow_state = PBM_OW_CPL;
        end
      end
      PBM_OW_CPL: begin
        if (cpl_ready_in) begin
          nxt_ow_state = PBM_OW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || !ONE_WORD) begin
      ow_state_ff <= PBM_OW_IDLE;
    end else begin
      ow_state_ff <= nxt_ow_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive bar master command stage

  // Upper lanes forced to zero outside the configured width
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rbm_valid_ff <= 1'b0;
      rbm_cmd_ff <= '0;
    end else if (rx_take) begin
      rbm_valid_ff <= 1'b1;
      rbm_cmd_ff.write <= rxreq_in.write;
      rbm_cmd_ff.addr <= rxreq_in.addr;
      rbm_cmd_ff.data <= rxreq_in.data & LANES;
    end else if (rbm_take) begin
      rbm_valid_ff <= 1'b0;
    end
  end

  assign rbm_cmd_out = rbm_cmd_ff;
  assign rbm_valid_out = rbm_valid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Outstanding read tags

  // Tag of the request in the command stage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cur_tag_ff <= '0;
    end else if (rx_take) begin
      cur_tag_ff <= rxreq_in.tag;
    end
  end

  // Tags pushed in issue order; the fabric returns reads in order
  always_ff @(posedge clk_in) begin
    if (rd_issue) begin
      tagq_mem[tagq_wptr_ff] <= cur_tag_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tagq_wptr_ff <= '0;
      tagq_rptr_ff <= '0;
      tagq_cnt_ff <= '0;
    end else begin
      if (rd_issue) begin
        tagq_wptr_ff <= tagq_wptr_ff + 1'b1;
      end
      if (rbm_rvalid_in && (tagq_cnt_ff != '0)) begin
        tagq_rptr_ff <= tagq_rptr_ff + 1'b1;
      end
      unique case ({rd_issue, rbm_rvalid_in && (tagq_cnt_ff != '0)})
        2'b10: tagq_cnt_ff <= tagq_cnt_ff + 1'b1;
        2'b01: tagq_cnt_ff <= tagq_cnt_ff - 1'b1;
        default: tagq_cnt_ff <= tagq_cnt_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion stage

  // Every mode answers incoming reads with completions
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cpl_valid_ff <= 1'b0;
      cpl_ff <= '0;
    end else if (rbm_rvalid_in && (tagq_cnt_ff != '0)) begin
      cpl_valid_ff <= 1'b1;
      cpl_ff.tag <= tagq_mem[tagq_rptr_ff];
      cpl_ff.data <= rbm_rdata_in & LANES;
    end else if (cpl_ready_in) begin
      cpl_valid_ff <= 1'b0;
    end
  end

  assign cpl_out = cpl_ff;
  assign cpl_valid_out = cpl_valid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit-side slave, full mode only

  // Port tied off in completer modes so nothing can originate upstream
  assign txs_ready_out = CAN_REQUEST && (!txreq_valid_ff || txreq_ready_in);
  assign tx_take = txs_valid_in && txs_ready_out;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      txreq_valid_ff <= 1'b0;
      txreq_ff <= '0;
    end else if (tx_take) begin
      txreq_valid_ff <= 1'b1;
      txreq_ff.write <= txs_cmd_in.write;
      txreq_ff.addr <= txs_cmd_in.addr;
      txreq_ff.data <= txs_cmd_in.data & LANES;
    end else if (txreq_ready_in) begin
      txreq_valid_ff <= 1'b0;
    end
  end

  assign txreq_out = txreq_ff;
  assign txreq_valid_out = txreq_valid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Bridge register slave

  // Interrupt enable: build option sets only the reset value
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_en_ff <= AUTO_IRQ_EN;
    end else if (BRS_PRESENT && brs_sel_in && brs_wr_in && (brs_addr_in == BRS_IRQ_EN_OFF)) begin
      irq_en_ff <= brs_wdata_in[IRQ_EN_BIT];
    end
  end

  // Reads answer one cycle later; unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      brs_rvalid_ff <= 1'b0;
      brs_rdata_ff <= '0;
    end else begin
      brs_rvalid_ff <= BRS_PRESENT && brs_sel_in && !brs_wr_in;
      if (BRS_PRESENT && brs_sel_in && !brs_wr_in) begin
        unique case (brs_addr_in)
          BRS_IRQ_EN_OFF: brs_rdata_ff <= WORD_W'(irq_en_ff);
          BRS_STATUS_OFF: brs_rdata_ff <= {
            {(WORD_W-TAGQ_CNT_W-4){1'b0}}, tagq_cnt_ff, ow_state_ff, PERIPH_MODE};
          BRS_CAP_OFF: brs_rdata_ff <= DEV_CAP_WORD;
          default: brs_rdata_ff <= '0;
        endcase
      end
    end
  end

  assign brs_rdata_out = brs_rdata_ff;
  assign brs_rvalid_out = brs_rvalid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration space read

  // Capability word is a constant; writes from the link have no path here
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cfg_rvalid_ff <= 1'b0;
      cfg_rdata_ff <= '0;
    end else begin
      cfg_rvalid_ff <= cfg_rd_in;
      if (cfg_rd_in) begin
        cfg_rdata_ff <= (cfg_addr_in == DEV_CAP_OFF) ? DEV_CAP_WORD : '0;
      end
    end
  end

  assign cfg_rdata_out = cfg_rdata_ff;
  assign cfg_rvalid_out = cfg_rvalid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt delivery

  // Legacy line gated by the enable; custom MSI interface only when built in
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_ff <= 1'b0;
      msi_ff <= '0;
    end else begin
      irq_ff <= app_irq_in && irq_en_ff && !MULTI_MSI;
      msi_ff <= MULTI_MSI ? app_msi_in : '0;
    end
  end

  assign irq_out = irq_ff;
  assign msi_out = msi_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Link power

  // No low power entry is ever requested; tolerance fields are advisory only
  assign standby_entry_out = 1'b0;
  assign sleep_entry_out = 1'b0;

endmodule : pbm_bridge_mode_config

// ==== testbench/pbm_bridge_props.sv ====
`timescale 1ns/10ps
module pbm_bridge_props
  import pbm_pkg::*;
#(
  parameter logic [2:0] STANDBY_TOL = STANDBY_TOL_64NS,
  parameter logic [2:0] SLEEP_TOL = SLEEP_TOL_1US,
  parameter bit ROOT_PORT = 1'b0,
  parameter bit BRS_OPTION = 1'b1,
  parameter pbm_mode_t PERIPH_MODE = PBM_MODE_REQ_CPL
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cfg_rd_in,
  input wire logic [CFG_ADDR_W-1:0] cfg_addr_in,
  input wire logic [WORD_W-1:0] cfg_rdata_out,
  input wire logic cfg_rvalid_out,
  input wire logic rxreq_valid_in,
  input wire logic rxreq_ready_out,
  input wire pbm_cmd_t rbm_cmd_out,
  input wire logic rbm_valid_out,
  input wire logic rbm_ready_in,
  input wire pbm_cpl_t cpl_out,
  input wire logic cpl_valid_out,
  input wire logic cpl_ready_in,
  input wire logic txs_valid_in,
  input wire logic txs_ready_out,
  input wire logic txreq_valid_out,
  input wire logic txreq_ready_in,
  input wire logic brs_sel_in,
  input wire logic brs_wr_in,
  input wire logic brs_rvalid_out,
  input wire logic app_irq_in,
  input wire logic irq_out,
  input wire logic standby_entry_out,
  input wire logic sleep_entry_out
);
  // Register port only in full mode or opted into completion-only
  localparam bit BRS_ON = (PERIPH_MODE == PBM_MODE_REQ_CPL) ||
    ((PERIPH_MODE == PBM_MODE_CPL_ONLY) && BRS_OPTION);
  // Root port builds show no tolerance fields
  localparam logic [31:0] CAP_EXP = ROOT_PORT ? 32'h0 :
    ((32'(SLEEP_TOL) << SLEEP_TOL_LSB) | (32'(STANDBY_TOL) << STANDBY_TOL_LSB));
  // One clock domain, so clocking and reset are stated once
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  // Capability reads answer after exactly one cycle, quiet otherwise
  a_cfg_answer: assert property (cfg_rd_in |=> cfg_rvalid_out)
    else $error("config read not answered");
  a_cfg_quiet: assert property (!cfg_rd_in |=> !cfg_rvalid_out)
    else $error("config answer without read");
  a_cap_fields: assert property (cfg_rd_in && cfg_addr_in == DEV_CAP_OFF |=>
    cfg_rdata_out == CAP_EXP)
    else $error("capability word fields wrong");
  a_no_low_power: assert property (!(standby_entry_out || sleep_entry_out))
    else $error("low power entry requested");
  //////////////////////////////////////////////////
  // Taken requests appear downstream next cycle and stand until accepted
  a_rx_forward: assert property (rxreq_valid_in && rxreq_ready_out |=> rbm_valid_out)
    else $error("taken request not forwarded");
  a_rbm_hold: assert property (rbm_valid_out && !rbm_ready_in |=>
    rbm_valid_out && $stable(rbm_cmd_out))
    else $error("fabric command dropped or changed");
  a_cpl_hold: assert property (cpl_valid_out && !cpl_ready_in |=>
    cpl_valid_out && $stable(cpl_out))
    else $error("completion dropped or changed");
  a_tx_forward: assert property (txs_valid_in && txs_ready_out |=> txreq_valid_out)
    else $error("transmit request not forwarded");
  a_brs_answer: assert property (brs_sel_in && !brs_wr_in |=>
    brs_rvalid_out == BRS_ON)
    else $error("register read answer wrong");
  a_one_outstanding: assert property (PERIPH_MODE == PBM_MODE_ONE_WORD &&
    (rbm_valid_out || cpl_valid_out) |-> !rxreq_ready_out)
    else $error("one word target took a second request");
  a_no_upstream: assert property (PERIPH_MODE != PBM_MODE_REQ_CPL |->
    !txs_ready_out && !txreq_valid_out)
    else $error("completer build originated a request");
  a_irq_gate: assert property (!app_irq_in |=> !irq_out)
    else $error("interrupt without source");

  // Main traffic seen at least once
  c_cpl_done: cover property (cpl_valid_out && cpl_ready_in);
  c_tx_done: cover property (txreq_valid_out && txreq_ready_in);
  c_irq_seen: cover property (irq_out);
endmodule : pbm_bridge_props

bind pbm_bridge_mode_config pbm_bridge_props #(.STANDBY_TOL(STANDBY_TOL),
  .SLEEP_TOL(SLEEP_TOL), .ROOT_PORT(ROOT_PORT), .BRS_OPTION(BRS_OPTION),
  .PERIPH_MODE(PERIPH_MODE)) u_props (.clk_in, .srst_in, .cfg_rd_in, .cfg_addr_in,
  .cfg_rdata_out, .cfg_rvalid_out, .rxreq_valid_in, .rxreq_ready_out, .rbm_cmd_out,
  .rbm_valid_out, .rbm_ready_in, .cpl_out, .cpl_valid_out, .cpl_ready_in, .txs_valid_in,
  .txs_ready_out, .txreq_valid_out, .txreq_ready_in, .brs_sel_in, .brs_wr_in,
  .brs_rvalid_out, .app_irq_in, .irq_out, .standby_entry_out, .sleep_entry_out);

// ==== testbench/pbm_fabric_model.sv ====
`timescale 1ns/10ps
module pbm_fabric_model
  import pbm_pkg::*;
#(
  parameter int unsigned LAT = 3
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire pbm_cmd_t rbm_cmd_in,
  input wire logic rbm_valid_in,
  output logic rbm_ready_out,
  output logic [DATA_W-1:0] rbm_rdata_out,
  output logic rbm_rvalid_out
);
  logic [7:0] wait_ff;
  logic [ADDR_W-1:0] addr_ff;

  // Accept only every other cycle, so the bridge always meets back-pressure
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rbm_ready_out <= 1'b0;
    end else begin
      rbm_ready_out <= rbm_valid_in && !rbm_ready_out;
    end
  end

  // Full-width read return after LAT cycles; idle lanes toggle, never hold
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wait_ff <= 8'h00;
      addr_ff <= '0;
      rbm_rvalid_out <= 1'b0;
      rbm_rdata_out <= '0;
    end else begin
      rbm_rvalid_out <= (wait_ff == 8'h01);
      rbm_rdata_out <= (wait_ff == 8'h01) ? {4{addr_ff}} : ~rbm_rdata_out;
      if (rbm_valid_in && rbm_ready_out && !rbm_cmd_in.write) begin
        wait_ff <= 8'(LAT);
        addr_ff <= rbm_cmd_in.addr;
      end else if (wait_ff != 8'h00) begin
        wait_ff <= wait_ff - 8'h01;
      end
    end
  end
endmodule : pbm_fabric_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import pbm_pkg::*;
  logic clk_in, srst_in, cfg_rd_in, cfg_rvalid_out, rxreq_valid_in, rxreq_ready_out;
  logic rbm_valid_out, rbm_ready_in, rbm_rvalid_in, cpl_valid_out, cpl_ready_in;
  logic txs_valid_in, txs_ready_out, txreq_valid_out, txreq_ready_in, brs_sel_in, brs_wr_in;
  logic brs_rvalid_out, app_irq_in, irq_out, standby_entry_out, sleep_entry_out;
  logic [CFG_ADDR_W-1:0] cfg_addr_in;
  logic [WORD_W-1:0] cfg_rdata_out, brs_wdata_in, brs_rdata_out;
  logic [BRS_ADDR_W-1:0] brs_addr_in;
  logic [DATA_W-1:0] rbm_rdata_in;
  pbm_rx_req_t rxreq_in;
  pbm_cmd_t rbm_cmd_out, txs_cmd_in, txreq_out;
  pbm_cpl_t cpl_out;
  pbm_msi_t app_msi_in, msi_out;
  logic ow_valid, rxreq_ready_ow, rbm_valid_ow, rbm_ready_ow, rbm_rvalid_ow, cpl_valid_ow;
  logic txs_ready_ow, brs_rvalid_ow, irq_ow;
  logic [WORD_W-1:0] cfg_rdata_ow;
  logic [DATA_W-1:0] rbm_rdata_ow;
  pbm_cmd_t rbm_cmd_ow;
  pbm_cpl_t cpl_ow;
  int n_fail = 0;
  int num_checks = 0;

  pbm_bridge_mode_config dut (.clk_in, .srst_in, .cfg_rd_in, .cfg_addr_in, .cfg_rdata_out,
    .cfg_rvalid_out, .rxreq_in, .rxreq_valid_in, .rxreq_ready_out, .rbm_cmd_out,
    .rbm_valid_out, .rbm_ready_in, .rbm_rdata_in, .rbm_rvalid_in, .cpl_out, .cpl_valid_out,
    .cpl_ready_in, .txs_cmd_in, .txs_valid_in, .txs_ready_out, .txreq_out, .txreq_valid_out,
    .txreq_ready_in, .brs_sel_in, .brs_wr_in, .brs_addr_in, .brs_wdata_in, .brs_rdata_out,
    .brs_rvalid_out, .app_irq_in, .app_msi_in, .irq_out, .msi_out, .standby_entry_out,
    .sleep_entry_out);
  pbm_fabric_model u_fab (.clk_in, .srst_in, .rbm_cmd_in(rbm_cmd_out),
    .rbm_valid_in(rbm_valid_out), .rbm_ready_out(rbm_ready_in),
    .rbm_rdata_out(rbm_rdata_in), .rbm_rvalid_out(rbm_rvalid_in));
  // Second build: one word target, root port, auto-enabled interrupt, nonzero tolerances
  pbm_bridge_mode_config #(.PERIPH_MODE(PBM_MODE_ONE_WORD), .ROOT_PORT(1'b1),
    .STANDBY_TOL(3'h5), .SLEEP_TOL(3'h2), .AUTO_IRQ_EN(1'b1)) dut_ow (.clk_in, .srst_in,
    .cfg_rd_in, .cfg_addr_in, .cfg_rdata_out(cfg_rdata_ow), .cfg_rvalid_out(), .rxreq_in,
    .rxreq_valid_in(ow_valid), .rxreq_ready_out(rxreq_ready_ow), .rbm_cmd_out(rbm_cmd_ow),
    .rbm_valid_out(rbm_valid_ow), .rbm_ready_in(rbm_ready_ow), .rbm_rdata_in(rbm_rdata_ow),
    .rbm_rvalid_in(rbm_rvalid_ow), .cpl_out(cpl_ow), .cpl_valid_out(cpl_valid_ow),
    .cpl_ready_in, .txs_cmd_in, .txs_valid_in, .txs_ready_out(txs_ready_ow), .txreq_out(),
    .txreq_valid_out(), .txreq_ready_in, .brs_sel_in, .brs_wr_in, .brs_addr_in,
    .brs_wdata_in, .brs_rdata_out(), .brs_rvalid_out(brs_rvalid_ow), .app_irq_in,
    .app_msi_in, .irq_out(irq_ow), .msi_out(), .standby_entry_out(), .sleep_entry_out());
  pbm_fabric_model u_fab_ow (.clk_in, .srst_in, .rbm_cmd_in(rbm_cmd_ow),
    .rbm_valid_in(rbm_valid_ow), .rbm_ready_out(rbm_ready_ow),
    .rbm_rdata_out(rbm_rdata_ow), .rbm_rvalid_out(rbm_rvalid_ow));

  // 40 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  //////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // One-cycle request pulse, answer looked at one cycle later
  task automatic cfg_rd(input logic [11:0] a, output logic [31:0] d);
    @(negedge clk_in);
    cfg_rd_in = 1'b1;
    cfg_addr_in = a;
    @(negedge clk_in);
    cfg_rd_in = 1'b0;
    d = cfg_rdata_out;
    chk(DATA_W'(cfg_rvalid_out), 1);
  endtask : cfg_rd

  task automatic brs_acc(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                         output logic [31:0] d);
    @(negedge clk_in);
    brs_sel_in = 1'b1;
    brs_wr_in = wr;
    brs_addr_in = a;
    brs_wdata_in = wd;
    @(negedge clk_in);
    brs_sel_in = 1'b0;
    d = brs_rdata_out;
    chk(DATA_W'(brs_rvalid_out), DATA_W'(!wr));
  endtask : brs_acc
  //////////////////////////////////////////////////
  task automatic t_cfg();
    logic [31:0] d;
    cfg_rd(DEV_CAP_OFF, d);
    chk(DATA_W'(cfg_rdata_ow), 0);
    chk(DATA_W'(d[STANDBY_TOL_LSB +: 3]), DATA_W'(STANDBY_TOL_64NS));
    chk(DATA_W'(d[SLEEP_TOL_LSB +: 3]), DATA_W'(SLEEP_TOL_1US));
    cfg_rd(12'h090, d);
    chk(DATA_W'(d), '0);
  endtask : t_cfg

  // Enable powers up clear, then software writes rule the line
  task automatic t_irq();
    logic [31:0] d;
    app_irq_in = 1'b1;
    app_msi_in = '{req: 1'b1, num: 5'h03};
    brs_acc(1'b0, BRS_IRQ_EN_OFF, 32'h0, d);
    chk(DATA_W'(d[IRQ_EN_BIT]), 0);
    chk(DATA_W'(brs_rvalid_ow), 0);
    chk(DATA_W'(irq_out), 0);
    brs_acc(1'b1, BRS_IRQ_EN_OFF, 32'h1, d);
    brs_acc(1'b0, BRS_IRQ_EN_OFF, 32'h0, d);
    chk(DATA_W'(d[IRQ_EN_BIT]), 1);
    chk(DATA_W'(irq_out), 1);
    brs_acc(1'b1, BRS_IRQ_EN_OFF, 32'h0, d);
    repeat (2) @(negedge clk_in);
    chk(DATA_W'(irq_out), 0);
    chk(DATA_W'(irq_ow), 1);
    chk(DATA_W'(msi_out), 0);
    app_irq_in = 1'b0;
  endtask : t_irq

  // Incoming request through to the fabric, reads through to a stalled completion
  task automatic t_rx(input logic wr, input logic [7:0] tg, input logic [31:0] a);
    @(negedge clk_in);
    rxreq_in = '{write: wr, tag: tg, addr: a, data: {4{~a}}};
    rxreq_valid_in = 1'b1;
    for (int i = 0; i < 20 && rxreq_ready_out !== 1'b1; i++) @(negedge clk_in);
    @(negedge clk_in);
    rxreq_valid_in = 1'b0;
    chk(DATA_W'(rbm_valid_out), 1);
    chk(DATA_W'({rbm_cmd_out.write, rbm_cmd_out.addr}), DATA_W'({wr, a}));
    chk(rbm_cmd_out.data, {4{~a}});
    if (!wr) begin
      for (int i = 0; i < 40 && cpl_valid_out !== 1'b1; i++) @(negedge clk_in);
      repeat (2) @(negedge clk_in);
      chk(DATA_W'(cpl_valid_out), 1);
      chk(DATA_W'(cpl_out.tag), DATA_W'(tg));
      chk(cpl_out.data, {4{a}});
      cpl_ready_in = 1'b1;
      @(negedge clk_in);
      cpl_ready_in = 1'b0;
    end
    repeat (3) @(negedge clk_in);
  endtask : t_rx

  // One word target: one read at a time, low lane only, freed by completion accept
  task automatic t_ow(input logic [7:0] tg, input logic [31:0] a);
    @(negedge clk_in);
    rxreq_in = '{write: 1'b0, tag: tg, addr: a, data: {4{~a}}};
    ow_valid = 1'b1;
    @(negedge clk_in);
    ow_valid = 1'b0;
    chk(DATA_W'(rxreq_ready_ow), 0);
    chk(rbm_cmd_ow.data, {{(DATA_W-WORD_W){1'b0}}, ~a});
    for (int i = 0; i < 40 && cpl_valid_ow !== 1'b1; i++) @(negedge clk_in);
    chk(DATA_W'(cpl_ow.tag), DATA_W'(tg));
    chk(cpl_ow.data, {{(DATA_W-WORD_W){1'b0}}, a});
    chk(DATA_W'(rxreq_ready_ow), 0);
    cpl_ready_in = 1'b1;
    @(negedge clk_in);
    cpl_ready_in = 1'b0;
    chk(DATA_W'(rxreq_ready_ow), 1);
  endtask : t_ow

  task automatic t_tx(input logic [31:0] a);
    @(negedge clk_in);
    txs_cmd_in = '{write: 1'b1, addr: a, data: {4{a}}};
    txs_valid_in = 1'b1;
    for (int i = 0; i < 20 && txs_ready_out !== 1'b1; i++) @(negedge clk_in);
    @(negedge clk_in);
    txs_valid_in = 1'b0;
    chk(DATA_W'(txreq_valid_out), 1);
    chk(DATA_W'({txreq_out.write, txreq_out.addr}), DATA_W'({1'b1, a}));
    chk(txreq_out.data, {4{a}});
    chk(DATA_W'(txs_ready_ow), 0);
    txreq_ready_in = 1'b1;
    @(negedge clk_in);
    txreq_ready_in = 1'b0;
    chk(DATA_W'(txreq_valid_out), 0);
  endtask : t_tx
  //////////////////////////////////////////////////
  // Sequence: reset three cycles, then each scenario
  initial begin
    {srst_in, cfg_rd_in, rxreq_valid_in, cpl_ready_in, txs_valid_in} = 5'h10;
    {txreq_ready_in, brs_sel_in, brs_wr_in, app_irq_in} = 4'h0;
    cfg_addr_in = '0;
    brs_addr_in = '0;
    brs_wdata_in = '0;
    rxreq_in = '0;
    txs_cmd_in = '0;
    app_msi_in = '0;
    ow_valid = 1'b0;
    repeat (3) @(negedge clk_in);
    srst_in = 1'b0;
    t_cfg();
    t_irq();
    t_rx(1'b0, 8'h5a, 32'h0000_1230);
    t_rx(1'b1, 8'h00, 32'h0000_4560);
    t_rx(1'b0, 8'ha5, 32'hffff_fffc);
    t_ow(8'h3c, 32'h0000_0abc);
    t_tx(32'h8000_0040);
    chk(DATA_W'({standby_entry_out, sleep_entry_out}), 0);
    complete_run();
  end

  // Scenarios need well under a thousand cycles
  initial begin
    #(25 * 4000);
    n_fail++;
    complete_run();
  end
endmodule : tb_top
